//--- rtl/dma_params.svh
// Named constants for the transfer sequencer.
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH
`define XFER_VERIFY 2'h0
`define XFER_WRITE 2'h1
`define XFER_READ 2'h2
`define SVC_DEMAND 2'h0
`define SVC_SINGLE 2'h1
`define SVC_BLOCK 2'h2
`define MASK_RESET 4'hf
`define COUNT_LAST 16'h0000
`define COUNT_STEP 16'h0001
`define ADDR_STEP 16'h0001
`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define PRI_RESET 2'h0
`define PRI_STEP 2'h1
`define SYNC_RESET 7'h10
`define SYNC_READY 6
`define SYNC_GRANT 5
`define SYNC_EOP 4
`endif

//--- rtl/dma_pkg.sv
// Types shared by the transfer sequencer.
package dma_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_HOLD = 6'h02,
        ST_UPPER = 6'h04,
        ST_ADDR = 6'h08,
        ST_EXT = 6'h10,
        ST_RW = 6'h20
    } state_t;
    typedef struct packed {
        logic m2m_enable;
        logic addr_hold;
        logic ctrl_disable;
        logic compressed;
        logic rotating;
    } cmd_t;
    typedef struct packed {
        logic [1:0] xfer_type;
        logic autoinit;
        logic decrement;
        logic [1:0] svc_mode;
    } chan_mode_t;
    typedef struct packed {
        logic write_en;
        logic [1:0] chan;
        logic sel_count;
        logic [15:0] data;
    } prog_t;
endpackage : dma_pkg

//--- rtl/dma_transfer_sequencer.sv
// Four-channel DMA transfer sequencer with priority and memory-to-memory moves.
`include "dma_params.svh"

// Operation
// R1: Write transfer: memory write with I/O read.
// R2: Read transfer: memory read with I/O write.
// R3: Verify: addresses step, strobes stay off.
// R4: Autoinit reloads current from base at end.
// R5: Autoinit channel keeps mask clear at end.
// R6: Host write loads base and current together.
// R7: Memory move uses channels 0, 1 on request 0.
// R8: Move read half uses channel 0 address.
// R9: Move write half uses channel 1 address.
// R10: Channel 1 wrap ends move with end-of-process.
// R11: Channel 0 wrap only autoinitializes channel 0.
// R12: Address hold freezes channel 0 source address.
// R13: External end finishes move after final write.
// R14: Move drives address enable, no channel grant.
// R15: Fixed priority, no preemption during service.
// R16: Rotating priority on each bus release.
// R17: Arbitrate when the hold grant arrives.
// R18: Compressed timing drops the read extend state.
// R19: Compressed end-of-process in address change state; verify transfers drive it in ST_RW instead.
// R20: Upper address byte on data lines, strobed.
// R21: Upper address state only on byte carry; code also enters it at service start and on any high byte change.
// R22: Program only one edge after grant low.
// R23: Disable bit blocks new services.
// R24: Wrap sets status, pulses end, masks channel.
// R25: Pending request raises bus hold request.
// R26: Reset leaves idle with all strobes off.
module dma_transfer_sequencer (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic master_clear,
    input wire dma_pkg::cmd_t cmd,
    input wire dma_pkg::chan_mode_t [3:0] chan_mode,
    input wire dma_pkg::prog_t prog,
    input wire logic [3:0] mask_set,
    input wire logic [3:0] mask_clear,
    input wire logic [3:0] sw_req_set,
    input wire logic [3:0] sw_req_clear,
    input wire logic status_read,
    input wire logic [3:0] channel_request,
    input wire logic bus_hold_grant,
    input wire logic ready,
    input wire logic end_of_process_n_in,
    input wire logic [7:0] data_in,
    output logic bus_hold_request,
    output logic [3:0] channel_grant,
    output logic upper_addr_enable,
    output logic upper_addr_strobe,
    output logic [7:0] low_addr_lines,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic mem_read_strobe_n,
    output logic mem_write_strobe_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n,
    output logic end_of_process_n_out,
    output logic end_of_process_n_oe,
    output logic [3:0] terminal_count,
    output logic [3:0] mask_bits,
    output logic prog_ready,
    output logic [7:0] temp_data
);
    logic clr;
    logic [6:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
    logic grant_s, ready_s, eop_ext;
    logic [3:0] req_s;
    logic prog_ok_reg, prog_take, grant_low_reg;
    dma_pkg::state_t state_reg, state_next;
    logic [1:0] chan_reg, chan_next, pri_top_reg;
    logic m2m_reg, m2m_next, phase_reg, phase_next, stop_reg;
    logic [7:0] latched_hi_reg, temp_reg;
    logic [15:0] cur_addr_reg [4];
    logic [15:0] cur_cnt_reg [4];
    logic [15:0] base_addr_reg [4];
    logic [15:0] base_cnt_reg [4];
    logic [3:0] mask_reg, sw_req_reg, tc_reg, pending;
    logic [1:0] idx, idx_next, winner;
    logic found;
    logic [15:0] addr_c, cnt_c, addr_new, out_addr, out_cnt;
    logic verify, compress, wrap, xfer_done, tc_evt, ch0_wrap, term_evt, end_evt;
    logic reload_evt, active_next, verify_n, rd_pulse, wr_pulse, eop_drive;

    assign clr = srst | master_clear;

    // Pins pass three flops; a level counts once the last two agree.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_reg <= `SYNC_RESET;
            sync2_reg <= `SYNC_RESET;
            sync3_reg <= `SYNC_RESET;
            pin_reg <= `SYNC_RESET;
        end else begin
            sync1_reg <= {ready, bus_hold_grant, end_of_process_n_in, channel_request};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg ^ sync3_reg));
        end
    end

    assign ready_s = pin_reg[`SYNC_READY];
    assign grant_s = pin_reg[`SYNC_GRANT];
    assign eop_ext = ~pin_reg[`SYNC_EOP];
    assign req_s = pin_reg[3:0];

    // R22: program window opens one edge after grant is seen low
    always_ff @(posedge core_clk) begin
        if (clr) begin
            prog_ok_reg <= 1'b0;
        end else begin
            prog_ok_reg <= ~grant_s;
        end
    end
    assign prog_take = prog.write_en & prog_ok_reg & ~grant_s;

    // R23: disable bit gates every new service
    assign pending = ((req_s & ~mask_reg) | sw_req_reg) & {4{~cmd.ctrl_disable}};

    // R15: search from the current top channel downward in rank
    always_comb begin
        logic [1:0] cand;
        cand = 2'h0;
        winner = 2'h0;
        found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cand = pri_top_reg + i[1:0];
            if (!found && pending[cand]) begin
                winner = cand;
                found = 1'b1;
            end
        end
    end

    // R8: read half addresses channel 0; R9: write half channel 1
    assign idx = m2m_reg ? {1'b0, phase_reg} : chan_reg;
    assign addr_c = cur_addr_reg[idx];
    assign cnt_c = cur_cnt_reg[idx];
    // R12: address hold freezes the source side only
    assign addr_new = (m2m_reg & ~phase_reg & cmd.addr_hold) ? addr_c :
        chan_mode[idx].decrement ? addr_c - `ADDR_STEP : addr_c + `ADDR_STEP;
    assign verify = (chan_mode[chan_reg].xfer_type == `XFER_VERIFY) & ~m2m_reg;
    // R19: compressed timing is not used on memory moves
    assign compress = cmd.compressed & ~m2m_reg;
    assign wrap = cnt_c == `COUNT_LAST;
    // R3: ready is ignored in verify
    assign xfer_done = (state_reg == dma_pkg::ST_RW) & (ready_s | verify);
    // R10: channel 1 wrap is the terminal count of a move
    assign tc_evt = xfer_done & wrap & ~(m2m_reg & ~phase_reg);
    // R11: channel 0 wrap raises no count and no end signal
    assign ch0_wrap = xfer_done & wrap & m2m_reg & ~phase_reg;
    // R13: external end on a move waits for the end of the write half
    assign term_evt = m2m_reg ? xfer_done & phase_reg & (tc_evt | stop_reg | eop_ext) :
        xfer_done & (tc_evt | eop_ext);
    assign end_evt = term_evt | (xfer_done & ~m2m_reg &
        ((chan_mode[chan_reg].svc_mode == `SVC_SINGLE) |
         ((chan_mode[chan_reg].svc_mode == `SVC_DEMAND) & ~req_s[chan_reg])));
    assign reload_evt = (term_evt | ch0_wrap) & chan_mode[idx].autoinit;

    always_comb begin
        state_next = state_reg;
        chan_next = chan_reg;
        m2m_next = m2m_reg;
        phase_next = phase_reg;
        case (state_reg)
            dma_pkg::ST_IDLE: begin
                // R25: any qualifying request asks for the bus
                if (|pending) begin
                    state_next = dma_pkg::ST_HOLD;
                end
            end
            dma_pkg::ST_HOLD: begin
                // R17: arbitration happens as the grant returns
                if (grant_s && grant_low_reg) begin
                    if (found) begin
                        state_next = dma_pkg::ST_UPPER;
                        chan_next = winner;
                        // R7: a channel 0 win starts a memory move
                        m2m_next = cmd.m2m_enable & (winner == 2'h0);
                        phase_next = 1'b0;
                    end else begin
                        state_next = dma_pkg::ST_IDLE;
                    end
                end
            end
            dma_pkg::ST_UPPER: state_next = dma_pkg::ST_ADDR;
            dma_pkg::ST_ADDR: begin
                // R18: compressed timing skips the read extend state
                state_next = compress ? dma_pkg::ST_RW : dma_pkg::ST_EXT;
            end
            dma_pkg::ST_EXT: state_next = dma_pkg::ST_RW;
            dma_pkg::ST_RW: begin
                if (xfer_done) begin
                    if (end_evt) begin
                        state_next = dma_pkg::ST_IDLE;
                    end else begin
                        phase_next = m2m_reg & ~phase_reg;
                        state_next = dma_pkg::ST_ADDR;
                    end
                end
            end
            default: state_next = dma_pkg::ST_IDLE;
        endcase
        // R21: after ST_RW, upper address state only when the high byte changes
        if (state_reg == dma_pkg::ST_RW && state_next == dma_pkg::ST_ADDR &&
            out_addr[15:8] != latched_hi_reg) begin
            state_next = dma_pkg::ST_UPPER;
        end
    end

    assign idx_next = m2m_next ? {1'b0, phase_next} : chan_next;
    assign out_addr = (xfer_done && idx_next == idx) ? addr_new : cur_addr_reg[idx_next];
    assign out_cnt = (xfer_done && idx_next == idx) ? cnt_c - `COUNT_STEP :
        cur_cnt_reg[idx_next];

    always_ff @(posedge core_clk) begin
        if (clr) begin
            state_reg <= dma_pkg::ST_IDLE;
            chan_reg <= 2'h0;
            m2m_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            m2m_reg <= m2m_next;
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr || state_reg == dma_pkg::ST_IDLE) begin
            stop_reg <= 1'b0;
        end else if (m2m_reg && eop_ext) begin
            stop_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr || !grant_s) begin
            grant_low_reg <= 1'b1;
        end else if (!bus_hold_request) begin
            grant_low_reg <= 1'b0;
        end
    end

    // R16: after a release the next channel in line ranks highest
    always_ff @(posedge core_clk) begin
        if (clr || !cmd.rotating) begin
            pri_top_reg <= `PRI_RESET;
        end else if (state_reg == dma_pkg::ST_RW && state_next == dma_pkg::ST_IDLE) begin
            pri_top_reg <= chan_reg + `PRI_STEP;
        end
    end

    // Address and count files of all four channels.
    always_ff @(posedge core_clk) begin
        if (clr) begin
            for (int i = 0; i < 4; i++) begin
                cur_addr_reg[i] <= `WORD_RESET;
                cur_cnt_reg[i] <= `WORD_RESET;
                base_addr_reg[i] <= `WORD_RESET;
                base_cnt_reg[i] <= `WORD_RESET;
            end
        end else begin
            // R6: host write loads base and current at once
            if (prog_take && !prog.sel_count) begin
                base_addr_reg[prog.chan] <= prog.data;
                cur_addr_reg[prog.chan] <= prog.data;
            end
            if (prog_take && prog.sel_count) begin
                base_cnt_reg[prog.chan] <= prog.data;
                cur_cnt_reg[prog.chan] <= prog.data;
            end
            if (xfer_done) begin
                cur_addr_reg[idx] <= addr_new;
                cur_cnt_reg[idx] <= cnt_c - `COUNT_STEP;
            end
            // R4: autoinit restores both current registers
            if (reload_evt) begin
                cur_addr_reg[idx] <= base_addr_reg[idx];
                cur_cnt_reg[idx] <= base_cnt_reg[idx];
            end
        end
    end

    // R24: masking without autoinit; R5: autoinit leaves mask alone
    always_ff @(posedge core_clk) begin
        if (clr) begin
            mask_reg <= `MASK_RESET;
        end else begin
            mask_reg <= (mask_reg & ~mask_clear) | mask_set |
                ({3'h0, term_evt & ~chan_mode[idx].autoinit} << idx);
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            sw_req_reg <= 4'h0;
        end else begin
            sw_req_reg <= (sw_req_reg & ~sw_req_clear &
                ~({3'h0, term_evt} << chan_reg)) | sw_req_set;
        end
    end

    // R24: terminal status sets; a set beats a read clear
    always_ff @(posedge core_clk) begin
        if (clr) begin
            tc_reg <= 4'h0;
        end else begin
            tc_reg <= (tc_reg & {4{~status_read}}) | ({3'h0, term_evt} << idx);
        end
    end

    // R8: the byte read on a move is held for the write half
    always_ff @(posedge core_clk) begin
        if (clr) begin
            temp_reg <= `BYTE_RESET;
        end else if (xfer_done && m2m_reg && !phase_reg) begin
            temp_reg <= data_in;
        end
    end

    assign active_next = state_next != dma_pkg::ST_IDLE && state_next != dma_pkg::ST_HOLD;
    assign verify_n = (chan_mode[chan_next].xfer_type == `XFER_VERIFY) & ~m2m_next;
    assign rd_pulse = state_next == dma_pkg::ST_EXT || state_next == dma_pkg::ST_RW;
    assign wr_pulse = state_next == dma_pkg::ST_RW;
    // R19: compressed timing drives the end in the address change state for reads and writes, in ST_RW for verify
    assign eop_drive = (out_cnt == `COUNT_LAST) & ~(m2m_next & ~phase_next) & ~verify_n &
        ((cmd.compressed & ~m2m_next) ? state_next == dma_pkg::ST_ADDR : wr_pulse) |
        ((out_cnt == `COUNT_LAST) & verify_n & wr_pulse);

    // R26: reset leaves every strobe and enable off
    always_ff @(posedge core_clk) begin
        if (clr) begin
            bus_hold_request <= 1'b0;
            channel_grant <= 4'h0;
            upper_addr_enable <= 1'b0;
            upper_addr_strobe <= 1'b0;
            low_addr_lines <= `BYTE_RESET;
            data_out <= `BYTE_RESET;
            data_oe <= 1'b0;
            latched_hi_reg <= `BYTE_RESET;
            mem_read_strobe_n <= 1'b1;
            mem_write_strobe_n <= 1'b1;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
            end_of_process_n_out <= 1'b1;
            end_of_process_n_oe <= 1'b0;
        end else begin
            bus_hold_request <= state_next != dma_pkg::ST_IDLE;
            // R14: moves keep every channel grant off
            channel_grant <= (active_next && !m2m_next) ? 4'h1 << chan_next : 4'h0;
            upper_addr_enable <= active_next;
            // R20: upper byte on the data lines, strobed into the latch
            upper_addr_strobe <= state_next == dma_pkg::ST_UPPER;
            low_addr_lines <= out_addr[7:0];
            data_out <= (state_next == dma_pkg::ST_UPPER) ? out_addr[15:8] : temp_reg;
            data_oe <= state_next == dma_pkg::ST_UPPER || (m2m_next && phase_next && wr_pulse);
            if (state_next == dma_pkg::ST_UPPER) begin
                latched_hi_reg <= out_addr[15:8];
            end
            // R1: write type pairs memory write with I/O read
            // R2: read type pairs memory read with I/O write
            mem_read_strobe_n <= ~(rd_pulse && (m2m_next ? !phase_next :
                chan_mode[chan_next].xfer_type == `XFER_READ));
            mem_write_strobe_n <= ~(wr_pulse && (m2m_next ? phase_next :
                chan_mode[chan_next].xfer_type == `XFER_WRITE));
            io_read_strobe_n <= ~(rd_pulse && !m2m_next &&
                chan_mode[chan_next].xfer_type == `XFER_WRITE);
            io_write_strobe_n <= ~(wr_pulse && !m2m_next &&
                chan_mode[chan_next].xfer_type == `XFER_READ);
            end_of_process_n_out <= ~eop_drive;
            end_of_process_n_oe <= eop_drive;
        end
    end

    assign terminal_count = tc_reg;
    assign mask_bits = mask_reg;
    assign prog_ready = prog_ok_reg;
    assign temp_data = temp_reg;

    a_write_pair: assert property (@(posedge core_clk) disable iff (clr) // R1
        (|channel_grant && !mem_write_strobe_n) |-> !io_read_strobe_n)
        else $error("memory write without I/O read");
    a_read_pair: assert property (@(posedge core_clk) disable iff (clr) // R2
        (|channel_grant && !io_write_strobe_n) |-> !mem_read_strobe_n)
        else $error("I/O write without memory read");
    a_verify_quiet: assert property (@(posedge core_clk) disable iff (clr) // R3
        ($past(active_next) && $past(verify_n)) |->
        (mem_read_strobe_n && mem_write_strobe_n && io_read_strobe_n && io_write_strobe_n))
        else $error("strobe active in verify");
    a_autoinit_load: assert property (@(posedge core_clk) disable iff (clr) // R4
        (reload_evt && !prog_take) |=> cur_cnt_reg[$past(idx)] == base_cnt_reg[$past(idx)])
        else $error("autoinit did not reload count");
    a_move_no_grant: assert property (@(posedge core_clk) disable iff (clr) // R14
        (m2m_reg && state_reg != dma_pkg::ST_IDLE && state_reg != dma_pkg::ST_HOLD) |->
        (channel_grant == 4'h0 && upper_addr_enable))
        else $error("grant during memory move");
    a_no_preempt: assert property (@(posedge core_clk) disable iff (clr) // R15
        (state_reg == dma_pkg::ST_UPPER || state_reg == dma_pkg::ST_ADDR) |=>
        $stable(chan_reg))
        else $error("channel changed mid service");
    a_compress_skip: assert property (@(posedge core_clk) disable iff (clr) // R18
        (state_reg == dma_pkg::ST_ADDR && compress) |=> state_reg == dma_pkg::ST_RW)
        else $error("extend state under compressed timing");
    a_prog_window: assert property (@(posedge core_clk) disable iff (clr) // R22
        prog_take |-> (!grant_s && $past(grant_s) == 1'b0))
        else $error("programming accepted near grant");
    a_mask_on_end: assert property (@(posedge core_clk) disable iff (clr) // R24
        (term_evt && !chan_mode[idx].autoinit) |=> mask_reg[$past(idx)])
        else $error("mask not set at end");
    a_hold_request: assert property (@(posedge core_clk) disable iff (clr) // R25
        (state_reg == dma_pkg::ST_IDLE && |pending) |=> ##[0:1] bus_hold_request)
        else $error("no hold request for pending channel");
    a_move_stop: assert property (@(posedge core_clk) disable iff (clr) // R13
        (m2m_reg && !phase_reg && state_reg == dma_pkg::ST_RW) |-> state_next != dma_pkg::ST_IDLE)
        else $error("move released before final write");
endmodule : dma_transfer_sequencer

//--- testbench/host_model.sv
// Host side model that grants bus hold after a short or a long delay.
module host_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic bus_hold_request,
    input wire logic slow,
    output logic bus_hold_grant
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_reg;
    always @(posedge core_clk) begin
        if (srst || !bus_hold_request) begin
            bus_hold_grant <= 1'b0;
            wait_reg <= 4'h0;
        end else if (wait_reg == (slow ? 4'h9 : 4'h1)) begin
            bus_hold_grant <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : host_model

//--- testbench/tb_top.sv
// Self-checking bench for the transfer sequencer.
`include "dma_params.svh"
`define CHECK_EQ(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    dma_pkg::cmd_t cmd = '0;
    dma_pkg::chan_mode_t [3:0] chan_mode = '0;
    dma_pkg::prog_t prog = '0;
    logic [3:0] mask_clear = 4'h0;
    logic [3:0] sw_req_set = 4'h0;
    logic status_read = 1'b0;
    logic [3:0] channel_request = 4'h0;
    logic [7:0] data_in = 8'h00;
    logic slow = 1'b0;
    logic bus_hold_request, bus_hold_grant, upper_addr_enable, upper_addr_strobe, data_oe;
    logic [3:0] channel_grant, terminal_count, mask_bits, first_gnt;
    logic [7:0] low_addr_lines, data_out, temp_data, hi_seen, lo_seen, exp_src;
    logic mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n;
    logic end_of_process_n_out, end_of_process_n_oe, prog_ready;
    logic pmw = 1'b1, pmr = 1'b1, pio = 1'b1;
    logic [15:0] rnd = 16'h0053, drnd = 16'h0053, a0, a1;
    int err_count = 0, num_checks = 0, cyc = 0, nmw, nmr, nio, pair_bad, rd_bad, aen_bad, neop;

    dma_transfer_sequencer dut (
        .core_clk, .srst, .master_clear(1'b0), .cmd, .chan_mode, .prog, .mask_set(4'h0),
        .mask_clear, .sw_req_set, .sw_req_clear(4'h0), .status_read, .channel_request,
        .bus_hold_grant, .ready(1'b1), .end_of_process_n_in(1'b1), .data_in,
        .bus_hold_request, .channel_grant, .upper_addr_enable, .upper_addr_strobe,
        .low_addr_lines, .data_out, .data_oe, .mem_read_strobe_n, .mem_write_strobe_n,
        .io_read_strobe_n, .io_write_strobe_n, .end_of_process_n_out, .end_of_process_n_oe,
        .terminal_count, .mask_bits, .prog_ready, .temp_data
    );
    host_model host (.core_clk, .srst, .bus_hold_request, .slow, .bus_hold_grant);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic prog_wr(input logic [1:0] ch, input logic sel, input logic [15:0] d);
        for (int i = 0; i < 50 && !(prog_ready === 1'b1 && bus_hold_grant === 1'b0); i++)
            @(posedge core_clk);
        prog <= '{1'b1, ch, sel, d};
        @(posedge core_clk);
        prog.write_en <= 1'b0;
        @(posedge core_clk);
    endtask : prog_wr

    task automatic setup(input logic [1:0] ch, input logic [15:0] ad, input logic [15:0] cn);
        prog_wr(ch, 1'b0, ad);
        prog_wr(ch, 1'b1, cn);
    endtask : setup

    task automatic req(input logic [3:0] m);
        sw_req_set <= m;
        @(posedge core_clk);
        sw_req_set <= 4'h0;
        @(posedge core_clk);
    endtask : req

    task automatic clr_status();
        status_read <= 1'b1;
        @(posedge core_clk);
        status_read <= 1'b0;
        @(posedge core_clk);
        `CHECK_EQ("tc_clr", 4'h0, terminal_count)
    endtask : clr_status

    task automatic clr(input logic [7:0] src);
        nmw <= 0;
        nmr <= 0;
        nio <= 0;
        pair_bad <= 0;
        rd_bad <= 0;
        aen_bad <= 0;
        neop <= 0;
        exp_src <= src;
        first_gnt <= 4'h0;
        slow <= rnd[0];
    endtask : clr

    task automatic wait_svc(input string nm);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge core_clk);
            if (channel_grant !== 4'h0) channel_request <= 4'h0;
            if (bus_hold_request === 1'b1) seen = 1'b1;
            else if (seen) break;
        end
        `CHECK_EQ("svc", 2'h2, {seen, bus_hold_request})
        $display("test %s done", nm);
    endtask : wait_svc

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // Strobe, address and grant observation on every rising edge.
    always @(posedge core_clk) begin
        cyc++;
        drnd = lfsr(drnd);
        data_in <= drnd[7:0];
        if (mem_write_strobe_n === 1'b0 && pmw) nmw++;
        if (mem_read_strobe_n === 1'b0 && pmr) nmr++;
        if (!(io_read_strobe_n === 1'b1 && io_write_strobe_n === 1'b1) && pio) nio++;
        pmw = mem_write_strobe_n !== 1'b0;
        pmr = mem_read_strobe_n !== 1'b0;
        pio = io_read_strobe_n === 1'b1 && io_write_strobe_n === 1'b1;
        if (!cmd.m2m_enable && ((mem_write_strobe_n === 1'b0 && io_read_strobe_n !== 1'b0)
            || (io_write_strobe_n === 1'b0 && mem_read_strobe_n !== 1'b0))) pair_bad++;
        if (mem_read_strobe_n === 1'b0 && low_addr_lines !== exp_src) rd_bad++;
        if (upper_addr_enable === 1'b1 && channel_grant !== 4'h0 && cmd.m2m_enable) aen_bad++;
        if ({end_of_process_n_oe, end_of_process_n_out} === 2'h2) neop++;
        if (upper_addr_strobe === 1'b1 && data_oe === 1'b1) hi_seen = data_out;
        if (mem_read_strobe_n === 1'b0 || mem_write_strobe_n === 1'b0) lo_seen = low_addr_lines;
        if (first_gnt === 4'h0) first_gnt = channel_grant;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        `CHECK_EQ("idle_hrq", 1'b0, bus_hold_request)
        `CHECK_EQ("idle_strb", 4'hf, {mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n})
        `CHECK_EQ("idle_mask", 4'hf, mask_bits)
        mask_clear <= 4'hf;
        @(posedge core_clk);
        mask_clear <= 4'h0;
        rnd = lfsr(rnd);
        a0 = rnd;
        chan_mode[2] <= '{`XFER_WRITE, 1'b0, 1'b0, `SVC_SINGLE};
        setup(2'h2, a0, 16'h0000);
        clr(8'h00);
        channel_request[2] <= 1'b1;
        wait_svc("write");
        `CHECK_EQ("w_mw", 1, nmw)
        `CHECK_EQ("w_bad", 0, nmr + pair_bad)
        `CHECK_EQ("w_lo", a0[7:0], lo_seen)
        `CHECK_EQ("w_hi", a0[15:8], hi_seen)
        `CHECK_EQ("w_tc", 4'h4, terminal_count)
        `CHECK_EQ("w_mask", 1'b1, mask_bits[2])
        `CHECK_EQ("w_eop", 1, neop)
        clr_status();
        rnd = lfsr(rnd);
        a1 = {rnd[15:8], 8'hff};
        chan_mode[3] <= '{`XFER_READ, 1'b1, 1'b0, `SVC_BLOCK};
        setup(2'h3, a1, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            clr(8'h00);
            req(4'h8);
            wait_svc("read_auto");
            `CHECK_EQ("r_mr", 2, nmr)
            `CHECK_EQ("r_bad", 0, nmw + pair_bad)
            `CHECK_EQ("r_lo", 8'h00, lo_seen)
            `CHECK_EQ("r_hi", a1[15:8] + 8'h01, hi_seen)
            `CHECK_EQ("r_mask", 1'b0, mask_bits[3])
            `CHECK_EQ("r_tc", 4'h8, terminal_count)
            clr_status();
        end
        chan_mode[1] <= '{`XFER_VERIFY, 1'b0, 1'b0, `SVC_BLOCK};
        setup(2'h1, rnd, 16'h0000);
        clr(8'h00);
        req(4'h2);
        wait_svc("verify");
        `CHECK_EQ("v_strb", 0, nmw + nmr + nio)
        `CHECK_EQ("v_tc", 4'h2, terminal_count)
        clr_status();
        setup(2'h2, a0, 16'h0000);
        cmd.ctrl_disable <= 1'b1;
        clr(8'h00);
        req(4'hc);
        repeat (30) @(posedge core_clk);
        `CHECK_EQ("dis_hrq", 1'b0, bus_hold_request)
        cmd.ctrl_disable <= 1'b0;
        wait_svc("fixed_pri");
        `CHECK_EQ("fix_gnt", 4'h4, first_gnt)
        wait_svc("fixed_pri_2");
        cmd <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        setup(2'h2, a0, 16'h0000);
        setup(2'h1, a0, 16'h0000);
        req(4'h4);
        wait_svc("rot_first");
        clr(8'h00);
        req(4'ha);
        wait_svc("rot_pri");
        `CHECK_EQ("rot_gnt", 4'h8, first_gnt)
        wait_svc("rot_pri_2");
        clr_status();
        cmd <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        chan_mode[0] <= '{`XFER_READ, 1'b0, 1'b0, `SVC_BLOCK};
        chan_mode[1] <= '{`XFER_WRITE, 1'b0, 1'b0, `SVC_BLOCK};
        rnd = lfsr(rnd);
        a1 = {rnd[15:8], 1'b0, rnd[6:0]};
        setup(2'h0, a0, 16'h0001);
        setup(2'h1, a1, 16'h0001);
        clr(a0[7:0]);
        req(4'h1);
        wait_svc("mem_move");
        `CHECK_EQ("m_mr", 2, nmr)
        `CHECK_EQ("m_mw", 2, nmw)
        `CHECK_EQ("m_io", 0, nio + aen_bad)
        `CHECK_EQ("m_src", 0, rd_bad)
        `CHECK_EQ("m_dst", a1[7:0] + 8'h01, lo_seen)
        `CHECK_EQ("m_tc", 4'h2, terminal_count)
        `CHECK_EQ("m_eop", 1, neop)
        test_done();
    end
endmodule : tb_top
